//--- rtl/isla_pkg.sv
// Constants, types and carriers for the two-wire slave with limit alert.
// Assumes one 40 MHz clock domain for everything that imports these names.
package isla_pkg;
    localparam int RES_W = 10;
    localparam int FIELD_LSB = 2;
    localparam int ALERT_MSB = 15;
    localparam int SYNC_W = 2;

    // Register pointer values; the bus word index equals the pointer
    localparam logic [7:0] IDX_RESULT = 8'h00;
    localparam logic [7:0] IDX_STATUS = 8'h01;
    localparam logic [7:0] IDX_CONFIG = 8'h02;
    localparam logic [7:0] IDX_LOW = 8'h03;
    localparam logic [7:0] IDX_HIGH = 8'h04;
    localparam logic [7:0] IDX_HYST = 8'h05;
    localparam logic [7:0] IDX_BUS = 8'h06;
    localparam int AVS_IDX_LSB = 2;
    localparam int AVS_IDX_W = 3;
    localparam int AVS_ADDR_MIN = 5;

    localparam int ST_UNDER = 0;
    localparam int ST_OVER = 1;
    localparam int CFG_W = 5;
    localparam int CFG_POL = 0;
    localparam int CFG_PIN_EN = 2;
    localparam int CFG_FLAG_EN = 3;
    localparam int CFG_HOLD = 4;

    localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
    localparam logic [RES_W-1:0] LOW_RESET = 10'h000;
    localparam logic [RES_W-1:0] HIGH_RESET = 10'h3ff;
    localparam logic [RES_W-1:0] HYST_RESET = 10'h000;
    localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;

    localparam logic [6:0] ADDR_BASE = 7'h50;
    localparam logic [6:0] ADDR_FIXED = 7'h54;
    localparam logic [4:0] MASTER_CODE_TOP = 5'h01;

    typedef enum logic [1:0] {
        PIN_GND = 2'h0,
        PIN_FLOAT = 2'h1,
        PIN_SUPPLY = 2'h2
    } isla_pin_t;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_RX = 6'h02,
        S_RX_ACK = 6'h04,
        S_TX = 6'h08,
        S_TX_ACK = 6'h10,
        S_IGNORE = 6'h20
    } isla_state_t;

    typedef enum logic [1:0] {
        KIND_ADDR = 2'h0,
        KIND_PTR = 2'h1,
        KIND_HI = 2'h2,
        KIND_LO = 2'h3
    } isla_kind_t;

    typedef struct packed {
        logic valid;
        logic [7:0] idx;
        logic [15:0] data;
    } isla_wr_t;

    typedef struct packed {
        logic done;
        logic [RES_W-1:0] result;
    } isla_conv_t;
endpackage

//--- rtl/isla_top.sv
// Two-wire register slave of a sampling converter with out-of-range alert.
// Assumes open-drain bus pins resolved outside, a conversion strobe on clk,
// and an Avalon-MM master on the same clock for the register window.
`timescale 1ns/1ps
module isla_top #(
    parameter bit HAS_ADDR_PINS = 1'b1,
    parameter int AVS_ADDR_W = 5
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b,
    input wire logic [1:0] addr_select_low_pin,
    input wire logic [1:0] addr_select_high_pin,
    input wire isla_pkg::isla_conv_t conv,
    output logic alert_out,
    input wire logic [AVS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    if (AVS_ADDR_W < isla_pkg::AVS_ADDR_MIN) begin : g_chk
        $error("AVS_ADDR_W too small for the register window");
    end

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [isla_pkg::SYNC_W-1:0] scl_sync_q;
    logic [isla_pkg::SYNC_W-1:0] sda_sync_q;
    logic [isla_pkg::SYNC_W-1:0] alo_sync_q;
    logic [isla_pkg::SYNC_W-1:0] alo_pin_q;
    logic [isla_pkg::SYNC_W-1:0] ahi_sync_q;
    logic [isla_pkg::SYNC_W-1:0] ahi_pin_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    isla_pkg::isla_state_t state_q;
    isla_pkg::isla_kind_t kind_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [15:0] word_q;
    logic ack_q;
    logic ack_phase_q;
    logic rw_q;
    logic byte_sel_q;
    logic sda_oe_b_q;
    logic hs_q;
    logic [7:0] ptr_q;
    logic [7:0] hi_q;
    isla_pkg::isla_wr_t i2c_wr_q;
    isla_pkg::isla_wr_t avs_wr;
    isla_pkg::isla_wr_t wr_port [2];
    logic [7:0] rx_byte;
    logic rx_done;
    logic [6:0] own_addr;
    logic addr_match;
    logic master_code;
    logic [15:0] rd_word;
    logic [isla_pkg::CFG_W-1:0] cfg_q;
    logic [isla_pkg::RES_W-1:0] low_q;
    logic [isla_pkg::RES_W-1:0] high_q;
    logic [isla_pkg::RES_W-1:0] hyst_q;
    logic [isla_pkg::RES_W-1:0] result_q;
    logic over_q;
    logic under_q;
    logic clr_over;
    logic clr_under;
    logic over_hit;
    logic over_rel;
    logic under_hit;
    logic under_rel;
    logic alert_act;
    logic alert_q;
    logic wait_q;
    logic [31:0] readdata_q;
    logic avs_req;
    logic avs_take;
    logic avs_hit;
    logic [7:0] avs_idx;

    // Reset release through two stages
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Pins come from outside; the first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            alo_sync_q <= 2'h0;
            alo_pin_q <= 2'h0;
            ahi_sync_q <= 2'h0;
            ahi_pin_q <= 2'h0;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
            alo_sync_q <= addr_select_low_pin;
            alo_pin_q <= alo_sync_q;
            ahi_sync_q <= addr_select_high_pin;
            ahi_pin_q <= ahi_sync_q;
        end
    end
    assign scl_s = scl_sync_q[1];
    assign sda_s = sda_sync_q[1];
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_c = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    function automatic logic [1:0] pin_code(input logic [1:0] lvl);
        case (lvl)
            isla_pkg::PIN_FLOAT: pin_code = 2'h0;
            isla_pkg::PIN_GND: pin_code = 2'h1;
            isla_pkg::PIN_SUPPLY: pin_code = 2'h2;
            default: pin_code = 2'h0;
        endcase
    endfunction

    assign own_addr = HAS_ADDR_PINS ? (isla_pkg::ADDR_BASE | {3'h0, pin_code(ahi_pin_q), pin_code(alo_pin_q)})
                                    : isla_pkg::ADDR_FIXED;
    assign rx_byte = {shift_q[6:0], sda_s};
    assign rx_done = (state_q == isla_pkg::S_RX) && scl_rise && (bit_cnt_q == 3'h7);
    assign addr_match = rx_byte[7:1] == own_addr;
    assign master_code = rx_byte[7:3] == isla_pkg::MASTER_CODE_TOP;

    function automatic logic two_byte(input logic [7:0] idx);
        two_byte = (idx != isla_pkg::IDX_STATUS) && (idx != isla_pkg::IDX_CONFIG);
    endfunction

    function automatic logic [15:0] reg_value(input logic [7:0] idx);
        case (idx)
            isla_pkg::IDX_RESULT: reg_value = {cfg_q[isla_pkg::CFG_FLAG_EN] & (over_q | under_q),
                                               3'h0, result_q, 2'h0};
            isla_pkg::IDX_STATUS: reg_value = {14'h0000, over_q, under_q};
            isla_pkg::IDX_CONFIG: reg_value = {11'h000, cfg_q};
            isla_pkg::IDX_LOW: reg_value = {4'h0, low_q, 2'h0};
            isla_pkg::IDX_HIGH: reg_value = {4'h0, high_q, 2'h0};
            isla_pkg::IDX_HYST: reg_value = {4'h0, hyst_q, 2'h0};
            isla_pkg::IDX_BUS: reg_value = {8'h00, own_addr, hs_q};
            default: reg_value = 16'h0000;
        endcase
    endfunction
    assign rd_word = reg_value(ptr_q);

    // Serial engine: samples on SCL rise, changes SDA only after SCL fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= isla_pkg::S_IDLE;
            kind_q <= isla_pkg::KIND_ADDR;
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            word_q <= 16'h0000;
            ack_q <= 1'b0;
            ack_phase_q <= 1'b0;
            rw_q <= 1'b0;
            byte_sel_q <= 1'b0;
            sda_oe_b_q <= 1'b1;
        end else if (stop_c) begin
            state_q <= isla_pkg::S_IDLE;
            sda_oe_b_q <= 1'b1;
        end else if (start_c) begin
            state_q <= isla_pkg::S_RX;
            kind_q <= isla_pkg::KIND_ADDR;
            bit_cnt_q <= 3'h0;
            ack_phase_q <= 1'b0;
            sda_oe_b_q <= 1'b1;
        end else begin
            case (state_q)
                isla_pkg::S_RX: begin
                    if (scl_rise) begin
                        shift_q <= rx_byte;
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            state_q <= isla_pkg::S_RX_ACK;
                            ack_phase_q <= 1'b0;
                            case (kind_q)
                                isla_pkg::KIND_ADDR: begin
                                    ack_q <= addr_match;
                                    rw_q <= rx_byte[0];
                                    kind_q <= isla_pkg::KIND_PTR;
                                end
                                isla_pkg::KIND_PTR: begin
                                    ack_q <= 1'b1;
                                    kind_q <= isla_pkg::KIND_HI;
                                end
                                isla_pkg::KIND_HI: begin
                                    ack_q <= 1'b1;
                                    kind_q <= isla_pkg::KIND_LO;
                                end
                                default: begin
                                    ack_q <= 1'b1;
                                    kind_q <= isla_pkg::KIND_HI;
                                end
                            endcase
                        end
                    end
                end
                isla_pkg::S_RX_ACK: begin
                    if (scl_fall) begin
                        if (!ack_phase_q) begin
                            ack_phase_q <= 1'b1;
                            sda_oe_b_q <= ~ack_q;
                        end else if (!ack_q) begin
                            state_q <= isla_pkg::S_IGNORE;
                            sda_oe_b_q <= 1'b1;
                        end else if (rw_q) begin
                            state_q <= isla_pkg::S_TX;
                            word_q <= rd_word;
                            tx_q <= two_byte(ptr_q) ? rd_word[15:8] : rd_word[7:0];
                            sda_oe_b_q <= two_byte(ptr_q) ? rd_word[15] : rd_word[7];
                            byte_sel_q <= 1'b1;
                            bit_cnt_q <= 3'h0;
                        end else begin
                            state_q <= isla_pkg::S_RX;
                            sda_oe_b_q <= 1'b1;
                            bit_cnt_q <= 3'h0;
                        end
                    end
                end
                isla_pkg::S_TX: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_q == 3'h0) begin
                            state_q <= isla_pkg::S_TX_ACK;
                            sda_oe_b_q <= 1'b1;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            sda_oe_b_q <= tx_q[6];
                        end
                    end
                end
                isla_pkg::S_TX_ACK: begin
                    if (scl_rise) begin
                        ack_q <= ~sda_s;
                    end else if (scl_fall) begin
                        if (ack_q) begin
                            state_q <= isla_pkg::S_TX;
                            bit_cnt_q <= 3'h0;
                            byte_sel_q <= ~byte_sel_q;
                            if (byte_sel_q && two_byte(ptr_q)) begin
                                tx_q <= word_q[7:0];
                                sda_oe_b_q <= word_q[7];
                            end else begin
                                word_q <= rd_word;
                                tx_q <= two_byte(ptr_q) ? rd_word[15:8] : rd_word[7:0];
                                sda_oe_b_q <= two_byte(ptr_q) ? rd_word[15] : rd_word[7];
                            end
                        end else begin
                            state_q <= isla_pkg::S_IGNORE;
                        end
                    end
                end
                isla_pkg::S_IGNORE: sda_oe_b_q <= 1'b1;
                isla_pkg::S_IDLE: sda_oe_b_q <= 1'b1;
                default: begin
                    state_q <= isla_pkg::S_IDLE;
                    sda_oe_b_q <= 1'b1;
                end
            endcase
        end
    end

    // Master code enters high speed; restarts keep it, a stop ends it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_q <= 1'b0;
        end else if (stop_c) begin
            hs_q <= 1'b0;
        end else if (rx_done && kind_q == isla_pkg::KIND_ADDR && master_code) begin
            hs_q <= 1'b1;
        end
    end

    // Pointer and write staging
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= isla_pkg::IDX_RESULT;
            hi_q <= 8'h00;
            i2c_wr_q <= '0;
        end else begin
            i2c_wr_q.valid <= 1'b0;
            if (rx_done && kind_q == isla_pkg::KIND_PTR) begin
                ptr_q <= rx_byte;
            end
            if (rx_done && kind_q == isla_pkg::KIND_HI) begin
                hi_q <= rx_byte;
                if (!two_byte(ptr_q)) begin
                    i2c_wr_q <= '{valid: 1'b1, idx: ptr_q, data: {8'h00, rx_byte}};
                end
            end
            if (rx_done && kind_q == isla_pkg::KIND_LO && two_byte(ptr_q)) begin
                i2c_wr_q <= '{valid: 1'b1, idx: ptr_q, data: {hi_q, rx_byte}};
            end
        end
    end

    // Avalon slave: one wait cycle, then a single accepting cycle
    assign avs_req = avs_read | avs_write;
    assign avs_take = avs_req & ~wait_q;
    assign avs_hit = (avs_address >> (isla_pkg::AVS_IDX_LSB + isla_pkg::AVS_IDX_W)) == '0;
    assign avs_idx = {5'h00, avs_address[isla_pkg::AVS_IDX_LSB +: isla_pkg::AVS_IDX_W]};
    always_comb begin
        avs_wr.valid = avs_write & ~wait_q & avs_hit;
        avs_wr.idx = avs_idx;
        avs_wr.data = avs_writedata[15:0];
        wr_port[0] = avs_wr;
        wr_port[1] = i2c_wr_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end else if (avs_take) begin
            wait_q <= 1'b1;
        end else if (avs_req) begin
            wait_q <= 1'b0;
            readdata_q <= (avs_read && avs_hit) ? {16'h0000, reg_value(avs_idx)} : 32'h0000_0000;
        end
    end

    // Both ports write; the serial write lands last when they collide
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= isla_pkg::CFG_RESET;
            low_q <= isla_pkg::LOW_RESET;
            high_q <= isla_pkg::HIGH_RESET;
            hyst_q <= isla_pkg::HYST_RESET;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (wr_port[p].valid) begin
                    case (wr_port[p].idx)
                        isla_pkg::IDX_CONFIG: cfg_q <= wr_port[p].data[isla_pkg::CFG_W-1:0];
                        isla_pkg::IDX_LOW: low_q <= wr_port[p].data[isla_pkg::FIELD_LSB +: isla_pkg::RES_W];
                        isla_pkg::IDX_HIGH: high_q <= wr_port[p].data[isla_pkg::FIELD_LSB +: isla_pkg::RES_W];
                        isla_pkg::IDX_HYST: hyst_q <= wr_port[p].data[isla_pkg::FIELD_LSB +: isla_pkg::RES_W];
                        default: ;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= isla_pkg::RESULT_RESET;
        end else if (conv.done) begin
            result_q <= conv.result;
        end
    end

    always_comb begin
        clr_over = 1'b0;
        clr_under = 1'b0;
        for (int p = 0; p < 2; p++) begin
            if (wr_port[p].valid && wr_port[p].idx == isla_pkg::IDX_STATUS) begin
                clr_over = clr_over | wr_port[p].data[isla_pkg::ST_OVER];
                clr_under = clr_under | wr_port[p].data[isla_pkg::ST_UNDER];
            end
        end
    end

    // Hits and releases only come on a conversion strobe; a status write can clear flags between samples
    assign over_hit = conv.done && (conv.result > high_q);
    assign under_hit = conv.done && (conv.result < low_q);
    assign over_rel = conv.done && !cfg_q[isla_pkg::CFG_HOLD] &&
                      (({1'b0, conv.result} + {1'b0, hyst_q}) < {1'b0, high_q});
    assign under_rel = conv.done && !cfg_q[isla_pkg::CFG_HOLD] &&
                       ({1'b0, conv.result} > ({1'b0, low_q} + {1'b0, hyst_q}));

    // A new hit beats a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            over_q <= 1'b0;
            under_q <= 1'b0;
        end else begin
            if (over_hit) begin
                over_q <= 1'b1;
            end else if (over_rel || clr_over) begin
                over_q <= 1'b0;
            end
            if (under_hit) begin
                under_q <= 1'b1;
            end else if (under_rel || clr_under) begin
                under_q <= 1'b0;
            end
        end
    end

    assign alert_act = cfg_q[isla_pkg::CFG_PIN_EN] & (over_q | under_q);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_q <= 1'b1;
        end else begin
            alert_q <= cfg_q[isla_pkg::CFG_POL] ? alert_act : ~alert_act;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_b = sda_oe_b_q;
    assign alert_out = alert_q;
    assign avs_readdata = readdata_q;
    assign avs_waitrequest = wait_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    addr_ack_a: assert property (rx_done && kind_q == isla_pkg::KIND_ADDR |=> ack_q == $past(addr_match))
        else $error("address acknowledge does not follow match");
    ptr_load_a: assert property (rx_done && kind_q == isla_pkg::KIND_PTR |=> ptr_q == $past(rx_byte))
        else $error("pointer not loaded from first write byte");
    hs_nack_a: assert property (rx_done && kind_q == isla_pkg::KIND_ADDR && master_code |=> hs_q && !ack_q)
        else $error("master code acked or high speed not entered");
    stop_hs_a: assert property (stop_c |=> !hs_q && state_q == isla_pkg::S_IDLE)
        else $error("stop did not leave high speed");
    ignore_rel_a: assert property (state_q == isla_pkg::S_IGNORE && !start_c |=> sda_oe_b_q)
        else $error("data line driven while ignoring");
    over_set_a: assert property (over_hit |=> over_q ##1 (over_q || $past(over_rel || clr_over)))
        else $error("over flag not set above upper limit");
    hold_keep_a: assert property (over_q && cfg_q[isla_pkg::CFG_HOLD] && !clr_over |=> over_q)
        else $error("held over flag dropped without a write");
    alert_level_a: assert property ((under_q && cfg_q[isla_pkg::CFG_PIN_EN] && cfg_q[isla_pkg::CFG_POL])[*2]
                                    |-> alert_out)
        else $error("alert output not active high");
    avs_answer_a: assert property (avs_req && avs_waitrequest |-> ##[0:1] !avs_waitrequest)
        else $error("bus request not answered in one cycle");
endmodule

//--- sim/isla_master.sv
// Behavioural two-wire bus master, 200 ns bit period.
// Assumes a pulled-up data wire resolved by the bench.
`timescale 1ns/1ps
module isla_master (
    output logic scl_in,
    output logic sda_m,
    input wire logic sda_in
);
    initial begin
        scl_in = 1'b1;
        sda_m = 1'b1;
    end
    // Clock stands high between frames; data moves 40 ns after the fall
    task automatic start();
        #40 sda_m = 1'b1;
        #60 scl_in = 1'b1;
        #50 sda_m = 1'b0;
        #50 scl_in = 1'b0;
    endtask
    task automatic stop();
        #40 sda_m = 1'b0;
        #60 scl_in = 1'b1;
        #50 sda_m = 1'b1;
        #50;
    endtask
    // Sampled late in the high phase, the slave drives a few clocks after the fall
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #40 sda_m = tx[i];
            #60 scl_in = 1'b1;
            #90 rx[i] = sda_in;
            #10 scl_in = 1'b0;
        end
    endtask
endmodule

//--- sim/isla_top_tb.sv
// Random and corner tests of the two-wire slave with limit alert.
// Assumes the master model and an Avalon master on clk.
`timescale 1ns/1ps
module isla_top_tb;
    logic clk = 1'b0, rst_b = 1'b0, scl_in, sda_m, sda_out, sda_oe_b, alert_out, avs_waitrequest, pol, sda_oe_b_fix;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [1:0] addr_select_low_pin = 2'h1, addr_select_high_pin = 2'h1;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [15:0] w;
    logic [9:0] hh, ll, hy;
    logic [8:0] rx;
    logic [6:0] dev;
    isla_pkg::isla_conv_t conv = '0;
    int n_errors = 0, total_checks = 0, cyc = 0;
    wire sda_in = sda_m & (sda_oe_b | sda_out) & sda_oe_b_fix;
    always #12.5 clk = ~clk;
    isla_top isla_top_inst (.*);
    // Pinless variant on the same wire; only the serial side is exercised
    isla_top #(.HAS_ADDR_PINS(1'b0)) isla_top_fixed_inst (.clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(), .sda_oe_b(sda_oe_b_fix), .addr_select_low_pin(addr_select_low_pin),
        .addr_select_high_pin(addr_select_high_pin), .conv(conv), .alert_out(), .avs_address(5'h00),
        .avs_read(1'b0), .avs_write(1'b0), .avs_writedata(32'h0), .avs_readdata(), .avs_waitrequest());
    isla_master isla_master_inst (.*);
    function automatic logic [6:0] exp_addr(input int h, input int l);
        logic [1:0] off[3] = '{2'h1, 2'h0, 2'h2};
        return 7'h50 + 7'(4 * off[h] + off[l]);
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic av(input logic wr, input logic [7:0] idx, input logic [15:0] d);
        @(posedge clk);
        avs_address <= {idx[2:0], 2'h0};
        avs_writedata <= {16'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic ack(input logic [7:0] b, input logic e, input string what);
        isla_master_inst.xfer({b, 1'b1}, rx);
        check({15'h0, rx[0]}, {15'h0, e}, what);
    endtask
    task automatic i2c_rd(input int n);
        isla_master_inst.start();
        ack({dev, 1'b1}, 1'b0, "rd addr");
        for (int i = 0; i < 2 * n; i++) begin
            isla_master_inst.xfer({8'hff, 1'(i == 2 * n - 1)}, rx);
            check({8'h0, rx[8:1]}, {8'h0, i[0] ? w[7:0] : w[15:8]}, "rd byte");
        end
        isla_master_inst.stop();
    endtask
    task automatic stat(input logic [1:0] e);
        av(1'b0, 8'h01, 16'h0);
        check(rd[15:0], {14'h0, e}, "status");
        check({15'h0, alert_out}, {15'h0, pol ~^ (|e)}, "alert pin");
    endtask
    task automatic step(input logic [9:0] r, input logic [1:0] e);
        @(posedge clk);
        conv <= '{1'b1, r};
        @(posedge clk);
        conv <= '{1'b0, ~r};
        stat(e);
        av(1'b0, 8'h00, 16'h0);
        check(rd[15:0], {|e, 3'h0, r, 2'h0}, "result");
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            $display("[FAIL] %0t timeout", $time);
            n_errors++;
            results();
        end
    end
    initial begin
        void'($urandom(11));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        av(1'b0, 8'h04, 16'h0);
        check(rd[15:0], 16'h0ffc, "high reset");
        av(1'b0, 8'h07, 16'h0);
        check(rd[15:0], 16'h0, "unmapped");
        for (int k = 0; k < 9; k++) begin
            addr_select_high_pin <= 2'(k / 3);
            addr_select_low_pin <= 2'(k % 3);
            dev = exp_addr(k / 3, k % 3);
            w = {4'h0, 10'($urandom), 2'h0};
            repeat (8) @(posedge clk);
            isla_master_inst.start();
            ack({dev, 1'b0}, 1'b0, "wr addr");
            ack(8'h04, 1'b0, "ptr");
            ack(w[15:8], 1'b0, "upper");
            ack(w[7:0], 1'b0, "lower");
            isla_master_inst.start();
            i2c_rd(1 + k % 3);
            av(1'b0, 8'h04, 16'h0);
            check(rd[15:0], w, "limit");
            isla_master_inst.start();
            ack({dev ^ 7'h08, 1'b0}, 1'b1, "foreign");
            ack(8'h00, 1'b1, "ignored");
            isla_master_inst.stop();
        end
        isla_master_inst.start();
        ack({7'h54, 1'b0}, 1'b0, "fixed addr");
        isla_master_inst.start();
        ack({5'h01, 3'($urandom)}, 1'b1, "master code");
        isla_master_inst.start();
        ack({dev, 1'b0}, 1'b0, "hs addr");
        isla_master_inst.start();
        ack({dev, 1'b0}, 1'b0, "hs again");
        av(1'b0, 8'h06, 16'h0);
        check(rd[15:0], {8'h0, dev, 1'b1}, "hs on");
        isla_master_inst.stop();
        av(1'b0, 8'h06, 16'h0);
        check(rd[15:0], {8'h0, dev, 1'b0}, "hs off");
        hh = 10'(600 + $urandom % 300);
        ll = 10'(100 + $urandom % 300);
        hy = 10'($urandom % 60);
        av(1'b1, 8'h05, {4'h0, hy, 2'h3});
        av(1'b0, 8'h05, 16'h0);
        check(rd[15:0], {4'h0, hy, 2'h0}, "hyst");
        av(1'b1, 8'h03, {4'h0, ll, 2'h0});
        av(1'b1, 8'h04, {4'h0, hh, 2'h0});
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            av(1'b1, 8'h02, {11'h0, 4'b0110, pol});
            step(hh + 10'h1, 2'h2);
            step(hh - hy, 2'h2);
            step(hh - hy - 10'h1, 2'h0);
            step(ll - 10'h1, 2'h1);
            av(1'b1, 8'h01, 16'h0001);
            stat(2'h0);
            step(ll - 10'h1, 2'h1);
            step(ll + hy, 2'h1);
            step(ll + hy + 10'h1, 2'h0);
            av(1'b1, 8'h02, {11'h0, 4'b1110, pol});
            step(hh + 10'h1, 2'h2);
            step(ll + hy + 10'h1, 2'h2);
            av(1'b1, 8'h01, 16'h0002);
            stat(2'h0);
        end
        results();
    end
endmodule
